// ==== pcr_pkg.sv ====
// constants for the loop-1 configuration and power-down register bank
package pcr_pkg;

	// ********************************************************************
	// register byte addresses
	// ********************************************************************
	localparam logic [15:0] PCR_ADDR_LOOP_FILTER = 16'h00B0;
	localparam logic [15:0] PCR_ADDR_MODE_LOCK   = 16'h00B1;
	localparam logic [15:0] PCR_ADDR_VCO1_MAN    = 16'h00B2;
	localparam logic [15:0] PCR_ADDR_VCO2_MAN    = 16'h00B3;
	localparam logic [15:0] PCR_ADDR_PD_MISC     = 16'h00B4;
	localparam logic [15:0] PCR_ADDR_REF_DIS     = 16'h00B5;
	localparam logic [15:0] PCR_ADDR_LOOP1_DIS   = 16'h00B6;
	localparam logic [15:0] PCR_ADDR_OUT_DIS     = 16'h00B7;
	localparam logic [15:0] PCR_ADDR_DLOOP_CAL   = 16'h00B8;

	// ********************************************************************
	// field positions
	// ********************************************************************
	localparam int PCR_PUMP_LSB     = 5;
	localparam int PCR_SERIES_LSB   = 3;
	localparam int PCR_CAP_LSB      = 1;
	localparam int PCR_POLE_BIT     = 0;
	localparam int PCR_SYNTH_BIT    = 3;
	localparam int PCR_LCOUNT_BIT   = 1;
	localparam int PCR_OVERRIDE_BIT = 0;
	localparam int PCR_OSCSEL_BIT   = 5;
	localparam int PCR_LOCKVAL_LSB  = 0;
	localparam int PCR_DOUBLER_BIT  = 0;
	localparam int PCR_REFDIS_LSB   = 0;
	localparam int PCR_LOOP1DIS_BIT = 4;
	localparam int PCR_DLOOP_LSB    = 2;
	localparam int PCR_CAL_LSB      = 0;

	// ********************************************************************
	// reset values
	// ********************************************************************
	localparam logic [2:0] PCR_RST_PUMP     = 3'h4;
	localparam logic [1:0] PCR_RST_SERIES   = 2'h1;
	localparam logic [1:0] PCR_RST_CAP      = 2'h1;
	localparam logic       PCR_RST_POLE     = 1'h1;
	localparam logic       PCR_RST_LCOUNT   = 1'h1;
	localparam logic       PCR_RST_OVERRIDE = 1'h0;
	localparam logic       PCR_RST_OSCSEL   = 1'h1;
	localparam logic [4:0] PCR_RST_LOCK_A   = 5'h0B;
	localparam logic [4:0] PCR_RST_LOCK_B   = 5'h00;
	localparam logic       PCR_RST_SYNTH    = 1'h0;
	localparam logic       PCR_RST_DOUBLER  = 1'h0;
	localparam logic       PCR_RST_LOOP1DIS = 1'h0;

	// ********************************************************************
	// analog settings decoded for the loop
	// ********************************************************************
	localparam logic [9:0] PCR_PUMP_STEP_UA = 10'h06E;

	// pump current in microamps, equal steps from the first step
	function automatic logic [9:0] pcr_pump_ua(input logic [2:0] code);
		logic [9:0] steps;
		steps = {7'h00, code} + 10'h001;
		pcr_pump_ua = 10'(steps * PCR_PUMP_STEP_UA);
	endfunction : pcr_pump_ua

	// parallel capacitor in picofarads
	function automatic logic [7:0] pcr_cap_pf(input logic [1:0] code);
		unique case (code)
			2'h0: pcr_cap_pf = 8'h28;
			2'h1: pcr_cap_pf = 8'h50;
			2'h2: pcr_cap_pf = 8'h8C;
			2'h3: pcr_cap_pf = 8'hC8;
		endcase
	endfunction : pcr_cap_pf

	// series resistor in ohms
	function automatic logic [10:0] pcr_series_ohm(input logic [1:0] code);
		unique case (code)
			2'h0: pcr_series_ohm = 11'h14A;
			2'h1: pcr_series_ohm = 11'h280;
			2'h2: pcr_series_ohm = 11'h4B0;
			2'h3: pcr_series_ohm = 11'h6FE;
		endcase
	endfunction : pcr_series_ohm

endpackage : pcr_pkg

// ==== pcr_lock_sel.sv ====
// manual lock selection for the loop-1 oscillators
`timescale 1ns/1ps
module pcr_lock_sel
	import pcr_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       override,
	input  wire logic       osc_sel,
	input  wire logic [4:0] lock_a,
	input  wire logic [4:0] lock_b,
	output logic            manual_active,
	output logic            osc_a_chosen,
	output logic [4:0]      lock_val
);

	// in automatic mode the loop's own lock logic owns the value; zero here
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			manual_active <= 1'b0;
			osc_a_chosen  <= 1'b1;
			lock_val      <= 5'h00;
		end else begin
			manual_active <= override; // [R6]
			osc_a_chosen  <= osc_sel; // [R7]
			if (!override) begin
				lock_val <= 5'h00;
			end else if (osc_sel) begin
				lock_val <= lock_a; // [R8]
			end else begin
				lock_val <= lock_b; // [R9]
			end
		end
	end

endmodule : pcr_lock_sel

// ==== pcr_regs.sv ====
// loop-1 configuration and chip power-down register bank
`timescale 1ns/1ps
// What this block does
// [R1] pump current 3 bits, reset 100b, 110-880uA
// [R2] series resistor 2 bits, reset 01b
// [R3] parallel capacitor 2 bits, reset 01b
// [R4] second pole bit, reset 1, higher resistance
// [R5] lock count bit, reset 1 (16ppm)
// [R6] lock override reset 0, 1 gives manual
// [R7] manual oscillator select, 1 first, reset 1
// [R8] first oscillator lock value, reset 01011b
// [R9] second oscillator lock value, reset zero
// [R10] synthesizer mode bit, reset 0
// [R11] software forces free-run with synth mode
// [R12] crystal doubler off bit, reset 0
// [R13] four reference disable bits, reset 0
// [R14] analog loop 1 disable, reset 0
// [R15] eight output disables, driver tristated
// [R16] two digital loop disables, reset 0
// [R17] two calibration hold bits, reset 0
// [R18] software writes reserved bits as zero
// [R19] all fields read/write, reset to defaults
module pcr_regs
	import pcr_pkg::*;
#(
	parameter int NUM_REFS    = 4,
	parameter int NUM_OUTPUTS = 8,
	parameter int NUM_DLOOPS  = 2
)(
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic [15:0]            reg_addr,
	input  wire logic                   reg_wr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_rd,
	output logic      [7:0]             reg_rdata,
	output logic                        reg_ack,
	output logic                        reg_miss,
	output logic      [2:0]             loop1_pump_current,
	output logic      [9:0]             loop1_pump_ua,
	output logic      [1:0]             loop1_series_res,
	output logic      [10:0]            loop1_series_ohm,
	output logic      [1:0]             loop1_parallel_cap,
	output logic      [7:0]             loop1_cap_pf,
	output logic                        loop1_second_pole,
	output logic                        loop1_lock_count_sel,
	output logic                        loop1_lock_override,
	output logic                        loop1_manual_osc_sel,
	output logic      [4:0]             loop1_osc_a_lock_val,
	output logic      [4:0]             loop1_osc_b_lock_val,
	output logic                        loop1_manual_active,
	output logic                        loop1_osc_a_chosen,
	output logic      [4:0]             loop1_active_lock_val,
	output logic                        loop1_synth_only,
	output logic                        xtal_doubler_off,
	output logic      [NUM_REFS-1:0]    ref_input_off,
	output logic                        analog_loop1_off,
	output logic      [NUM_OUTPUTS-1:0] output_off,
	output logic      [NUM_OUTPUTS-1:0] output_drive_en,
	output logic      [NUM_DLOOPS-1:0]  digital_loop_off,
	output logic      [1:0]             loop_cal_hold
);

	// ********************************************************************
	// elaboration checks
	// ********************************************************************
	// each group has to fit its byte without moving neighbouring fields
	if (NUM_REFS < 1 || NUM_REFS > 4) begin : g_bad_refs
		$error("NUM_REFS must lie between 1 and 4");
	end
	if (NUM_OUTPUTS < 1 || NUM_OUTPUTS > 8) begin : g_bad_outs
		$error("NUM_OUTPUTS must lie between 1 and 8");
	end
	if (NUM_DLOOPS < 1 || NUM_DLOOPS > 2) begin : g_bad_dloops
		$error("NUM_DLOOPS must lie between 1 and 2");
	end

	// ********************************************************************
	// decoded reset values
	// ********************************************************************
	// worked out once here so the asynchronous reset loads plain constants
	localparam logic [9:0]  RST_PUMP_UA    = pcr_pump_ua(PCR_RST_PUMP);
	localparam logic [10:0] RST_SERIES_OHM = pcr_series_ohm(PCR_RST_SERIES);
	localparam logic [7:0]  RST_CAP_PF     = pcr_cap_pf(PCR_RST_CAP);

	// ********************************************************************
	// address decode
	// ********************************************************************
	logic hit_filter;
	logic hit_mode;
	logic hit_vco1;
	logic hit_vco2;
	logic hit_misc;
	logic hit_ref;
	logic hit_loop1;
	logic hit_out;
	logic hit_dloop;
	logic hit_any;

	assign hit_filter = (reg_addr == PCR_ADDR_LOOP_FILTER);
	assign hit_mode   = (reg_addr == PCR_ADDR_MODE_LOCK);
	assign hit_vco1   = (reg_addr == PCR_ADDR_VCO1_MAN);
	assign hit_vco2   = (reg_addr == PCR_ADDR_VCO2_MAN);
	assign hit_misc   = (reg_addr == PCR_ADDR_PD_MISC);
	assign hit_ref    = (reg_addr == PCR_ADDR_REF_DIS);
	assign hit_loop1  = (reg_addr == PCR_ADDR_LOOP1_DIS);
	assign hit_out    = (reg_addr == PCR_ADDR_OUT_DIS);
	assign hit_dloop  = (reg_addr == PCR_ADDR_DLOOP_CAL);
	assign hit_any    = hit_filter | hit_mode | hit_vco1 | hit_vco2 |
	                    hit_misc | hit_ref | hit_loop1 | hit_out | hit_dloop;

	// ********************************************************************
	// loop-1 filter register
	// ********************************************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			loop1_pump_current <= PCR_RST_PUMP; // [R1]
			loop1_series_res   <= PCR_RST_SERIES; // [R2]
			loop1_parallel_cap <= PCR_RST_CAP; // [R3]
			loop1_second_pole  <= PCR_RST_POLE; // [R4]
		end else if (reg_wr && hit_filter) begin
			loop1_pump_current <= reg_wdata[PCR_PUMP_LSB +: 3]; // [R1]
			loop1_series_res   <= reg_wdata[PCR_SERIES_LSB +: 2]; // [R2]
			loop1_parallel_cap <= reg_wdata[PCR_CAP_LSB +: 2]; // [R3]
			loop1_second_pole  <= reg_wdata[PCR_POLE_BIT]; // [R4]
		end
	end

	// ********************************************************************
	// decoded analog settings
	// ********************************************************************
	// decoded analog values follow the codes one cycle later
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			loop1_pump_ua    <= RST_PUMP_UA;
			loop1_series_ohm <= RST_SERIES_OHM;
			loop1_cap_pf     <= RST_CAP_PF;
		end else begin
			loop1_pump_ua    <= pcr_pump_ua(loop1_pump_current); // [R1]
			loop1_series_ohm <= pcr_series_ohm(loop1_series_res); // [R2]
			loop1_cap_pf     <= pcr_cap_pf(loop1_parallel_cap); // [R3]
		end
	end

	// ********************************************************************
	// loop-1 mode and lock registers
	// ********************************************************************
	// synth mode needs the digital loop forced to free-run by software;
	// that field lives elsewhere, so nothing here enforces it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			loop1_synth_only     <= PCR_RST_SYNTH; // [R10]
			loop1_lock_count_sel <= PCR_RST_LCOUNT; // [R5]
			loop1_lock_override  <= PCR_RST_OVERRIDE; // [R6]
		end else if (reg_wr && hit_mode) begin
			loop1_synth_only     <= reg_wdata[PCR_SYNTH_BIT]; // [R10]
			loop1_lock_count_sel <= reg_wdata[PCR_LCOUNT_BIT]; // [R5]
			loop1_lock_override  <= reg_wdata[PCR_OVERRIDE_BIT]; // [R6]
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			loop1_manual_osc_sel <= PCR_RST_OSCSEL; // [R7]
			loop1_osc_a_lock_val <= PCR_RST_LOCK_A; // [R8]
		end else if (reg_wr && hit_vco1) begin
			loop1_manual_osc_sel <= reg_wdata[PCR_OSCSEL_BIT]; // [R7]
			loop1_osc_a_lock_val <= reg_wdata[PCR_LOCKVAL_LSB +: 5]; // [R8]
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			loop1_osc_b_lock_val <= PCR_RST_LOCK_B; // [R9]
		end else if (reg_wr && hit_vco2) begin
			loop1_osc_b_lock_val <= reg_wdata[PCR_LOCKVAL_LSB +: 5]; // [R9]
		end
	end

	// ********************************************************************
	// manual lock selection
	// ********************************************************************

	pcr_lock_sel u_lock_sel (
		.ref_clk       (ref_clk),
		.rst           (rst),
		.override      (loop1_lock_override),
		.osc_sel       (loop1_manual_osc_sel),
		.lock_a        (loop1_osc_a_lock_val),
		.lock_b        (loop1_osc_b_lock_val),
		.manual_active (loop1_manual_active),
		.osc_a_chosen  (loop1_osc_a_chosen),
		.lock_val      (loop1_active_lock_val)
	);

	// ********************************************************************
	// power-down registers
	// ********************************************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			xtal_doubler_off <= PCR_RST_DOUBLER; // [R12]
		end else if (reg_wr && hit_misc) begin
			xtal_doubler_off <= reg_wdata[PCR_DOUBLER_BIT]; // [R12]
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ref_input_off <= '0; // [R13]
		end else if (reg_wr && hit_ref) begin
			ref_input_off <= reg_wdata[PCR_REFDIS_LSB +: NUM_REFS]; // [R13]
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			analog_loop1_off <= PCR_RST_LOOP1DIS; // [R14]
		end else if (reg_wr && hit_loop1) begin
			analog_loop1_off <= reg_wdata[PCR_LOOP1DIS_BIT]; // [R14]
		end
	end

	// the drive enable is a second flop so the pad sees a clean level
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			output_off      <= '0; // [R15]
			output_drive_en <= '1;
		end else if (reg_wr && hit_out) begin
			output_off      <= reg_wdata[NUM_OUTPUTS-1:0]; // [R15]
			output_drive_en <= ~reg_wdata[NUM_OUTPUTS-1:0]; // [R15]
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			digital_loop_off <= '0; // [R16]
			loop_cal_hold    <= 2'h0; // [R17]
		end else if (reg_wr && hit_dloop) begin
			digital_loop_off <= reg_wdata[PCR_DLOOP_LSB +: NUM_DLOOPS]; // [R16]
			loop_cal_hold    <= reg_wdata[PCR_CAL_LSB +: 2]; // [R17]
		end
	end

	// ********************************************************************
	// read-back
	// ********************************************************************
	// reserved bits are not stored: software must write them as zero,
	// and they read as zero, which saves flops
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = 8'h00;
		if (hit_filter) begin
			next_rdata[PCR_PUMP_LSB +: 3]   = loop1_pump_current;
			next_rdata[PCR_SERIES_LSB +: 2] = loop1_series_res;
			next_rdata[PCR_CAP_LSB +: 2]    = loop1_parallel_cap;
			next_rdata[PCR_POLE_BIT]        = loop1_second_pole;
		end else if (hit_mode) begin
			next_rdata[PCR_SYNTH_BIT]    = loop1_synth_only;
			next_rdata[PCR_LCOUNT_BIT]   = loop1_lock_count_sel;
			next_rdata[PCR_OVERRIDE_BIT] = loop1_lock_override;
		end else if (hit_vco1) begin
			next_rdata[PCR_OSCSEL_BIT]       = loop1_manual_osc_sel;
			next_rdata[PCR_LOCKVAL_LSB +: 5] = loop1_osc_a_lock_val;
		end else if (hit_vco2) begin
			next_rdata[PCR_LOCKVAL_LSB +: 5] = loop1_osc_b_lock_val;
		end else if (hit_misc) begin
			next_rdata[PCR_DOUBLER_BIT] = xtal_doubler_off;
		end else if (hit_ref) begin
			next_rdata[PCR_REFDIS_LSB +: NUM_REFS] = ref_input_off;
		end else if (hit_loop1) begin
			next_rdata[PCR_LOOP1DIS_BIT] = analog_loop1_off;
		end else if (hit_out) begin
			next_rdata[NUM_OUTPUTS-1:0] = output_off;
		end else if (hit_dloop) begin
			next_rdata[PCR_DLOOP_LSB +: NUM_DLOOPS] = digital_loop_off;
			next_rdata[PCR_CAL_LSB +: 2]            = loop_cal_hold;
		end
	end

	// read data holds until the next read; unmapped reads give zero
	// a write in the same cycle lands after the old value is read
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata; // [R19]
		end
	end

	// one-cycle answer to every access, with a miss flag beside it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_ack  <= 1'b0;
			reg_miss <= 1'b0;
		end else begin
			reg_ack  <= reg_wr | reg_rd;
			reg_miss <= (reg_wr | reg_rd) & ~hit_any;
		end
	end

endmodule : pcr_regs

// ==== pcr_regs_props.sv ====
// concurrent checks on the loop-1 and power-down register bank ports
`timescale 1ns/1ps
module pcr_regs_props
	import pcr_pkg::*;
#(
	parameter int NUM_OUTPUTS = 8
)(
	input wire logic                   ref_clk,
	input wire logic                   rst,
	input wire logic [15:0]            reg_addr,
	input wire logic                   reg_wr,
	input wire logic [7:0]             reg_wdata,
	input wire logic                   reg_rd,
	input wire logic [7:0]             reg_rdata,
	input wire logic                   reg_ack,
	input wire logic                   reg_miss,
	input wire logic [2:0]             loop1_pump_current,
	input wire logic [9:0]             loop1_pump_ua,
	input wire logic [1:0]             loop1_series_res,
	input wire logic [10:0]            loop1_series_ohm,
	input wire logic [1:0]             loop1_parallel_cap,
	input wire logic [7:0]             loop1_cap_pf,
	input wire logic                   loop1_lock_override,
	input wire logic                   loop1_manual_osc_sel,
	input wire logic [4:0]             loop1_osc_a_lock_val,
	input wire logic                   loop1_manual_active,
	input wire logic [4:0]             loop1_active_lock_val,
	input wire logic [NUM_OUTPUTS-1:0] output_off,
	input wire logic [NUM_OUTPUTS-1:0] output_drive_en
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ****************************************************************
	// sequences and properties
	// ****************************************************************
	sequence s_req;
		reg_wr || reg_rd;
	endsequence
	sequence s_miss_rd;
		reg_rd && !reg_wr && (reg_addr == 16'h00B9);
	endsequence
	property p_ack;
		s_req |=> reg_ack ##1 !reg_ack || $past(reg_wr || reg_rd);
	endproperty
	property p_no_ack;
		!(reg_wr || reg_rd) |=> !reg_ack && !reg_miss;
	endproperty
	property p_miss_rd;
		s_miss_rd |=> reg_ack && reg_miss && (reg_rdata == 8'h00);
	endproperty
	property p_pump_ua;
		1'b1 |=> loop1_pump_ua ==
			10'((10'($past(loop1_pump_current)) + 10'h001) * 10'h06E);
	endproperty
	property p_series;
		(loop1_series_res == 2'h1) |=> (loop1_series_ohm == 11'h280);
	endproperty
	property p_cap;
		(loop1_parallel_cap == 2'h3) |=> (loop1_cap_pf == 8'hC8);
	endproperty
	property p_manual;
		1'b1 |=> loop1_manual_active == $past(loop1_lock_override);
	endproperty
	property p_lock_a;
		loop1_lock_override && loop1_manual_osc_sel |=>
			loop1_active_lock_val == $past(loop1_osc_a_lock_val);
	endproperty
	property p_out_wr;
		reg_wr && (reg_addr == PCR_ADDR_OUT_DIS) |=>
			output_off == NUM_OUTPUTS'($past(reg_wdata));
	endproperty
	property p_drive;
		output_drive_en == ~output_off;
	endproperty
	property p_hold;
		!reg_wr |=> $stable(loop1_pump_current) && $stable(output_off);
	endproperty
	// ****************************************************************
	// assertions
	// ****************************************************************
	a_ack: assert property (p_ack) else $error("ack not one cycle");
	a_no_ack: assert property (p_no_ack) else $error("stray ack");
	a_miss_rd: assert property (p_miss_rd) else $error("bad miss");
	a_pump_ua: assert property (p_pump_ua) else $error("pump ua");
	a_series: assert property (p_series) else $error("series ohm");
	a_cap: assert property (p_cap) else $error("cap pf");
	a_manual: assert property (p_manual) else $error("manual");
	a_lock_a: assert property (p_lock_a) else $error("lock val");
	a_out_wr: assert property (p_out_wr) else $error("output off");
	a_drive: assert property (p_drive) else $error("drive en");
	a_hold: assert property (p_hold) else $error("field moved");
endmodule : pcr_regs_props

bind pcr_regs pcr_regs_props #(.NUM_OUTPUTS(NUM_OUTPUTS)) u_props (
	.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.reg_ack(reg_ack), .reg_miss(reg_miss),
	.loop1_pump_current(loop1_pump_current), .loop1_pump_ua(loop1_pump_ua),
	.loop1_series_res(loop1_series_res),
	.loop1_series_ohm(loop1_series_ohm),
	.loop1_parallel_cap(loop1_parallel_cap), .loop1_cap_pf(loop1_cap_pf),
	.loop1_lock_override(loop1_lock_override),
	.loop1_manual_osc_sel(loop1_manual_osc_sel),
	.loop1_osc_a_lock_val(loop1_osc_a_lock_val),
	.loop1_manual_active(loop1_manual_active),
	.loop1_active_lock_val(loop1_active_lock_val),
	.output_off(output_off), .output_drive_en(output_drive_en));

// ==== pcr_regs_tb.sv ====
// self-checking bench for the loop-1 and power-down register bank
`timescale 1ns/1ps
module pcr_regs_tb;
	import pcr_pkg::*;
	logic ref_clk, rst, reg_wr, reg_rd, ack, miss, pole, lcnt, ovr, osel;
	logic mact, ach, synth, dbl, l1off;
	logic [15:0] reg_addr;
	logic [7:0]  reg_wdata, rdata, pf, oof, den;
	logic [2:0]  pump;
	logic [9:0]  ua;
	logic [10:0] ohm;
	logic [1:0]  ser, cap, dloff, cal;
	logic [4:0]  lka, lkb, alv;
	logic [3:0]  refoff;
	int errors, n_tests;
	logic last_miss;

	pcr_regs dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(rdata), .reg_ack(ack), .reg_miss(miss),
		.loop1_pump_current(pump), .loop1_pump_ua(ua),
		.loop1_series_res(ser), .loop1_series_ohm(ohm),
		.loop1_parallel_cap(cap), .loop1_cap_pf(pf),
		.loop1_second_pole(pole), .loop1_lock_count_sel(lcnt),
		.loop1_lock_override(ovr), .loop1_manual_osc_sel(osel),
		.loop1_osc_a_lock_val(lka), .loop1_osc_b_lock_val(lkb),
		.loop1_manual_active(mact), .loop1_osc_a_chosen(ach),
		.loop1_active_lock_val(alv), .loop1_synth_only(synth),
		.xtal_doubler_off(dbl), .ref_input_off(refoff),
		.analog_loop1_off(l1off), .output_off(oof),
		.output_drive_en(den), .digital_loop_off(dloff),
		.loop_cal_hold(cal));

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1 chk(16'(ack), 16'h1);
		last_miss = miss;
		@(posedge ref_clk);
		#1;
	endtask : wr
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(16'(ack), 16'h1);
		last_miss = miss;
		chk(16'(rdata), 16'(e));
	endtask : rd
	task print_verdict;
		if (errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task t_reset;
		logic [7:0] e [9];
		e = '{8'h8B, 8'h02, 8'h2B, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 9; i++) rd(16'h00B0 + 16'(i), e[i]);
		chk(16'(ua), 16'h226);
		chk(16'(ohm), 16'h280);
		chk(16'(pf), 16'h50);
		chk(16'({lcnt, ovr, osel, synth}), 16'hA);
		chk(16'({lka, lkb, alv}), 16'h2C00);
		chk(16'(den), 16'hFF);
	endtask : t_reset
	task t_filter;
		wr(PCR_ADDR_LOOP_FILTER, 8'hFF);
		chk(16'({pump, ser, cap, pole}), 16'hFF);
		chk(16'(ua), 16'h370);
		chk(16'(ohm), 16'h6FE);
		chk(16'(pf), 16'hC8);
		wr(PCR_ADDR_LOOP_FILTER, 8'h00);
		chk({ua, 5'h00, pole}, 16'h1B80);
		chk(16'(ohm), 16'h14A);
		chk(16'(pf), 16'h28);
		rd(PCR_ADDR_LOOP_FILTER, 8'h00);
	endtask : t_filter
	task t_lock;
		// synth mode relies on the digital loop being forced to free-run
		wr(PCR_ADDR_MODE_LOCK, 8'h09);
		rd(PCR_ADDR_MODE_LOCK, 8'h09);
		chk(16'({synth, lcnt, ovr}), 16'h5);
		wr(PCR_ADDR_VCO2_MAN, 8'h15);
		wr(PCR_ADDR_VCO1_MAN, 8'h3F);
		chk(16'({mact, ach, alv}), 16'h7F);
		wr(PCR_ADDR_VCO1_MAN, 8'h04);
		chk({ach, alv, lka, lkb}, 16'h5495);
		rd(PCR_ADDR_VCO2_MAN, 8'h15);
	endtask : t_lock
	task t_power;
		logic [7:0] e [5];
		e = '{8'h01, 8'h0F, 8'h10, 8'hA5, 8'h0F};
		// write and read together: the read returns the old contents
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_rd    <= 1'b1;
		reg_addr  <= PCR_ADDR_LOOP1_DIS;
		reg_wdata <= 8'h10;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 chk(16'(rdata), 16'h00);
		chk(16'(ack), 16'h1);
		wr(PCR_ADDR_PD_MISC, 8'h01);
		wr(PCR_ADDR_REF_DIS, 8'h0F);
		wr(PCR_ADDR_OUT_DIS, 8'hA5);
		wr(PCR_ADDR_DLOOP_CAL, 8'h0F);
		for (int i = 0; i < 5; i++) rd(16'h00B4 + 16'(i), e[i]);
		chk(16'({dbl, refoff, l1off}), 16'h3F);
		chk({oof, den}, 16'hA55A);
		chk(16'({dloff, cal}), 16'hF);
	endtask : t_power
	task t_miss;
		wr(16'h00B9, 8'h00);
		chk(16'(last_miss), 16'h1);
		rd(16'h00B9, 8'h00);
		chk(16'(last_miss), 16'h1);
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd(PCR_ADDR_OUT_DIS, 8'h00);
		chk({pump, 5'h00, den}, 16'h80FF);
	endtask : t_miss

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// the whole sequence is under a hundred cycles; this is ample margin
	initial begin
		#100000;
		errors++;
		print_verdict;
	end
	initial begin
		rst       = 1'b1;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 16'h0000;
		reg_wdata = 8'h00;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset;
		t_filter;
		t_lock;
		t_power;
		t_miss;
		print_verdict;
	end
endmodule : pcr_regs_tb
